// >>> rtl/code_fifo.sv
// Purpose: Small FIFO holding character codes ahead of the generator
// Assumes: One clock, valid/ready on both sides
// Notes:   Full and empty are exact; depth need not be a power of two
`timescale 1ns/1ps
module code_fifo #(
    parameter int WIDTH = 7,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];   // Word storage
    logic [PW-1:0]    wrPtr;           // Next write slot
    logic [PW-1:0]    rdPtr;           // Next read slot
    logic [PW:0]      fill;            // Words held
    logic             push;
    logic             pop;

    assign inReady  = (fill != (PW+1)'(DEPTH));
    assign outValid = (fill != '0);
    assign outData  = store[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Pointer step with wrap at DEPTH
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // Storage write
    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            fill  <= '0;
        end else begin
            if (push) begin
                wrPtr <= bump(wrPtr);
            end
            if (pop) begin
                rdPtr <= bump(rdPtr);
            end
            if (push && !pop) begin
                fill <= fill + (PW+1)'(1);
            end else if (pop && !push) begin
                fill <= fill - (PW+1)'(1);
            end
        end
    end
endmodule

// >>> rtl/stroke_char_gen.sv
// Purpose: Stroke character generator, six columns by eight dots
// Assumes: dot_step_clock and power_init_pulse arrive from pins
// Notes:   Codes wait in a FIFO; ROMs are loaded through romWrite
//
// Functional notes
// [RULE_01] Display 127 codes decoded from character words
// [RULE_02] Six 256 by 4 pattern ROMs
// [RULE_03] Start bottom of column 1, X step, up
// [RULE_04] Each column end steps X, reverses ramp
// [RULE_05] Bit count times load, delay, advance, clear
// [RULE_06] End of character presets bit counter to 12
// [RULE_07] Monitor delay is four steps plus adjustable
// [RULE_08] Count 12..15, 0..10, clear on eleventh
// [RULE_09] Done at bit 11 in column 6
// [RULE_10] 4-bit column counter with 4-to-10 decoder
// [RULE_11] End of character presets column counter to 15
// [RULE_12] Column count selects the ROM pair
// [RULE_13] Clear at 11 only while column below 8
// [RULE_14] Two ROMs form each 8-bit column
// [RULE_15] ROM outputs are wired OR
// [RULE_16] Matrix blocks map to ROM addresses
// [RULE_17] Beam unblank follows dot intensity
// [RULE_18] ROM split by code half and column
// [RULE_19] Load shift register at count two
// [RULE_20] Shift direction alternates per column
// [RULE_21] Intensity pulse about 350 ns
// [RULE_22] Done raises end of character, waits
// [RULE_23] No pulses for zeros or idle states
`timescale 1ns/1ps
module stroke_char_gen #(
    parameter int COL_DELAY  = stroke_char_pkg::COL_DELAY_CYCLES,
    parameter int PULSE_LEN  = stroke_char_pkg::INTENSITY_CYCLES,
    parameter int FIFO_DEPTH = stroke_char_pkg::FIFO_DEPTH
) (
    input  wire logic                                sys_clk,
    input  wire logic                                rst_n,
    input  wire logic                                power_init_pulse,
    input  wire logic                                dot_step_clock,
    input  wire logic [stroke_char_pkg::CODE_W-1:0]  charCode,
    input  wire logic                                charValid,
    output logic                                     charReady,
    input  wire stroke_char_pkg::rom_write_t         romWrite,
    output logic                                     end_of_char_n,
    output logic                                     char_done,
    output logic                                     dot_intensity,
    output logic                                     beam_unblank_out_n,
    output logic                                     shift_load_n,
    output logic                                     column_msb_n,
    output logic                                     first_column_n,
    output logic                                     last_column_n,
    output stroke_char_pkg::monitor_timing_t         timing
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int CW = stroke_char_pkg::CODE_W;
    localparam int AW = stroke_char_pkg::ROM_AW;
    localparam int DW = stroke_char_pkg::ROM_DW;

    typedef enum logic [1:0] {IDLE, RUN, FINISH} gen_state_t;

    gen_state_t    state;                // Run control state
    logic [2:0]    stepSync;             // Step clock synchroniser
    logic [1:0]    initSync;             // Init pin synchroniser
    logic          step;                 // One cycle per step rising edge
    logic [3:0]    bitCount;             // Bit (Y) counter
    logic [3:0]    colCount;             // Column (X) counter
    logic [3:0]    next_bitCount;        // Bit counter next value
    logic [CW-1:0] code;                 // Current character code
    logic [7:0]    shiftReg;             // Output shift register
    logic          shiftRight;           // Shift mode for this column
    logic [15:0]   delayCount;           // Column delay single shot
    logic [15:0]   pulseCount;           // Intensity single shot
    logic [DW-1:0] rom [stroke_char_pkg::ROM_COUNT][stroke_char_pkg::ROM_DEPTH];
    logic [DW-1:0] romOut [stroke_char_pkg::ROM_COUNT];  // Per ROM read
    logic [7:0]    colData;              // Wired-OR column data
    logic [CW-1:0] fifoData;             // FIFO head
    logic          fifoValid;            // FIFO holds a code
    logic          fifoTake;             // Pop the FIFO
    logic          wrapCol;              // Column advance on bit clear
    logic          startCol;             // First column entry on wrap
    logic          dotBit;               // Bit leaving the register
    logic [9:0]    colDec;               // Decoded column lines

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // 4-to-10 line decoder, one-hot, nothing above nine
    function automatic logic [9:0] decode10(input logic [3:0] c);
        decode10 = (c < 4'ha) ? (10'h001 << c) : 10'h000;
    endfunction

    // Enable for one ROM by code half and column count
    function automatic logic romEnable(input int idx, input logic [CW-1:0] cd,
                                       input logic [3:0] cc);
        logic lowCols;
        lowCols = (cc[3:2] == 2'b00);
        case (idx)
            0, 1:    romEnable = lowCols && !cd[6];
            2, 3:    romEnable = lowCols && cd[6];
            default: romEnable = (cc[3:1] == 3'h2);
        endcase
    endfunction

    // ROM address by matrix block of the column
    function automatic logic [AW-1:0] romAddr(input int idx, input logic [CW-1:0] cd,
                                              input logic [3:0] cc);
        if (idx < 4) begin
            romAddr = {cd[5:0], cc[1:0]};
        end else begin
            romAddr = {cd[6:0], cc[0]};
        end
    endfunction

    // ----------------------------------------------------------------
    // Code FIFO
    // ----------------------------------------------------------------
    assign fifoTake = fifoValid && (state == IDLE);

    code_fifo #(
        .WIDTH (CW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .inData   (charCode),
        .inValid  (charValid),
        .inReady  (charReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoTake)
    );

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two flops per pin plus a third on the step pin, edge found behind the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stepSync <= 3'h0;
            initSync <= 2'h0;
        end else begin
            stepSync <= {stepSync[1:0], dot_step_clock};
            initSync <= {initSync[0], power_init_pulse};
        end
    end

    assign step = stepSync[1] && !stepSync[2];

    // ----------------------------------------------------------------
    // Pattern ROMs
    // ----------------------------------------------------------------
    // Loading port for the six pattern stores
    always_ff @(posedge sys_clk) begin
        if (romWrite.we && (romWrite.sel < 3'h6)) begin
            rom[romWrite.sel][romWrite.addr] <= romWrite.data;  // [RULE_02]
        end
    end

    // Each disabled ROM floats to zero so the OR is a wired OR
    always_comb begin
        for (int i = 0; i < stroke_char_pkg::ROM_COUNT; i++) begin
            romOut[i] = romEnable(i, code, colCount) ?               // [RULE_12] [RULE_18]
                        rom[i][romAddr(i, code, colCount)] : '0;    // [RULE_16]
        end
        colData = {romOut[1] | romOut[3] | romOut[5],               // [RULE_15]
                   romOut[0] | romOut[2] | romOut[4]};              // [RULE_14]
    end

    // ----------------------------------------------------------------
    // Counter decisions
    // ----------------------------------------------------------------
    // Clear at 11 only while the column count is 0 to 7; column 6 ends instead
    assign wrapCol  = (bitCount == stroke_char_pkg::BIT_LAST) && !colCount[3] && // [RULE_13]
                      (colCount != stroke_char_pkg::COL_LAST);
    // Overflow 15 to 0 while preset to 15 enters column 1
    assign startCol = (bitCount == 4'hf) && (colCount == stroke_char_pkg::COL_PRESET);

    // Bit counter next value
    always_comb begin
        if (wrapCol) begin
            next_bitCount = 4'h0;                      // [RULE_08]
        end else begin
            next_bitCount = bitCount + 4'h1;           // [RULE_08]
        end
    end

    assign colDec = decode10(colCount);                // [RULE_10]

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    // Idle takes a code, run counts, finish issues end of character
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= IDLE;
            code  <= '0;
        end else if (initSync[1]) begin
            state <= IDLE;
        end else begin
            case (state)
                IDLE: begin
                    if (fifoTake) begin
                        code  <= fifoData;             // [RULE_01]
                        state <= RUN;
                    end
                end
                RUN: begin
                    if (step && (bitCount == stroke_char_pkg::BIT_LAST) &&
                        (colCount == stroke_char_pkg::COL_LAST)) begin
                        state <= FINISH;               // [RULE_09]
                    end
                end
                FINISH: begin
                    state <= IDLE;                     // [RULE_22]
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Bit and column counters
    // ----------------------------------------------------------------
    // Preset on end of character, step only while running
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCount <= stroke_char_pkg::BIT_PRESET;
            colCount <= stroke_char_pkg::COL_PRESET;
        end else if (initSync[1] || state == FINISH) begin
            bitCount <= stroke_char_pkg::BIT_PRESET;   // [RULE_06]
            colCount <= stroke_char_pkg::COL_PRESET;   // [RULE_11]
        end else if (state == RUN && step) begin
            bitCount <= next_bitCount;                 // [RULE_05]
            if (wrapCol || startCol) begin
                colCount <= colCount + 4'h1;           // [RULE_05] [RULE_10]
            end
        end
    end

    // ----------------------------------------------------------------
    // Output shift register
    // ----------------------------------------------------------------
    // Load at count two, then shift one place per step
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftReg <= 8'h00;
        end else if (state != RUN) begin
            shiftReg <= 8'h00;
        end else if (step && next_bitCount == stroke_char_pkg::BIT_LOAD && !startCol) begin
            shiftReg <= colData;                       // [RULE_19]
        end else if (step) begin
            if (shiftRight) begin
                shiftReg <= {1'b0, shiftReg[7:1]};     // [RULE_20]
            end else begin
                shiftReg <= {shiftReg[6:0], 1'b0};     // [RULE_20]
            end
        end
    end

    // Mode: reset per character, toggled at each column advance on bit clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftRight <= 1'b1;
        end else if (state != RUN) begin
            shiftRight <= 1'b1;
        end else if (step && wrapCol) begin
            shiftRight <= !shiftRight;                 // [RULE_20]
        end
    end

    // Up column sends bit 1 first, down column bit 8 first
    assign dotBit = shiftRight ? shiftReg[0] : shiftReg[7];

    // ----------------------------------------------------------------
    // Intensity single shot
    // ----------------------------------------------------------------
    // Fires per one bit in a dot slot of an active column
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulseCount <= 16'h0000;
        end else if (state == FINISH || initSync[1]) begin
            pulseCount <= 16'h0000;                    // [RULE_23]
        end else if (state == RUN && step && dotBit && !colCount[3] &&
                     (bitCount >= stroke_char_pkg::BIT_LOAD) &&
                     (bitCount <= stroke_char_pkg::BIT_DOT_END)) begin
            pulseCount <= 16'(PULSE_LEN);              // [RULE_21] [RULE_23]
        end else if (pulseCount != 16'h0000) begin
            pulseCount <= pulseCount - 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Column delay single shot
    // ----------------------------------------------------------------
    // Runs the adjustable part of the monitor delay at each X step
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            delayCount <= 16'h0000;
        end else if (state == RUN && step && (wrapCol || startCol)) begin
            delayCount <= 16'(COL_DELAY);              // [RULE_05] [RULE_07]
        end else if (delayCount != 16'h0000) begin
            delayCount <= delayCount - 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Monitor timing outputs
    // ----------------------------------------------------------------
    // X step on column entry, ramp turns, space after column 6
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timing <= '0;
        end else begin
            timing.xStep     <= state == RUN && step && (wrapCol || startCol); // [RULE_03] [RULE_04]
            timing.colDelay  <= (delayCount != 16'h0000); // [RULE_07]
            timing.charSpace <= (state == FINISH); // [RULE_04]
            if (state != RUN) begin
                timing.rampUp <= 1'b1; // [RULE_03]
            end else if (step && wrapCol) begin
                timing.rampUp <= !timing.rampUp; // [RULE_04]
            end
        end
    end

    // ----------------------------------------------------------------
    // Status and beam outputs
    // ----------------------------------------------------------------
    // Registered copies of decodes and the intensity stream
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            end_of_char_n      <= 1'b1;
            char_done          <= 1'b0;
            dot_intensity      <= 1'b0;
            beam_unblank_out_n <= 1'b1;
            shift_load_n       <= 1'b1;
            column_msb_n       <= 1'b1;
            first_column_n     <= 1'b1;
            last_column_n      <= 1'b1;
        end else begin
            end_of_char_n      <= !(state == FINISH || initSync[1]); // [RULE_06] [RULE_22]
            char_done          <= (state == FINISH); // [RULE_09]
            dot_intensity      <= (pulseCount != 16'h0000); // [RULE_21]
            beam_unblank_out_n <= (pulseCount == 16'h0000); // [RULE_17]
            shift_load_n       <= !(state == RUN && bitCount == stroke_char_pkg::BIT_LOAD); // [RULE_19]
            column_msb_n       <= colCount[3]; // [RULE_13]
            first_column_n     <= !colDec[0]; // [RULE_10]
            last_column_n      <= !colDec[5]; // [RULE_10]
        end
    end

endmodule

// >>> rtl/stroke_char_pkg.sv
// Purpose: Shared constants and types of the stroke character generator
// Assumes: sys_clk at 250 MHz
// Notes:   Every timing count is derived from its time in ns
package stroke_char_pkg;

    // ----------------------------------------------------------------
    // Clock and times
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 4;     // sys_clk period
    localparam int STEP_PERIOD_NS   = 400;   // Character clock period
    localparam int MONITOR_STEPS    = 4;     // Step periods in monitor delay
    localparam int COL_DELAY_NS     = 1200;  // Nominal adjustable delay
    localparam int INTENSITY_NS     = 350;   // Dot intensity pulse
    // Least time rounds up
    localparam int COL_DELAY_CYCLES = (COL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time rounds down
    localparam int INTENSITY_CYCLES = INTENSITY_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Counters and matrix
    // ----------------------------------------------------------------
    localparam logic [3:0] BIT_PRESET  = 4'hc;  // Bit counter preset (12)
    localparam logic [3:0] BIT_LAST    = 4'hb;  // Final bit count (11)
    localparam logic [3:0] BIT_LOAD    = 4'h2;  // Shift register load count
    localparam logic [3:0] BIT_DOT_END = 4'h9;  // Last dot count of a column
    localparam logic [3:0] COL_PRESET  = 4'hf;  // Column counter preset (15)
    localparam logic [3:0] COL_LAST    = 4'h5;  // Count of column 6
    localparam int         CODE_W      = 7;     // Character code width
    localparam int         ROM_COUNT   = 6;     // Character ROMs
    localparam int         ROM_DEPTH   = 256;   // Words per ROM
    localparam int         ROM_AW      = 8;     // ROM address width
    localparam int         ROM_DW      = 4;     // ROM data width
    localparam int         FIFO_DEPTH  = 4;     // Code FIFO depth

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Write port for loading the pattern ROMs
    typedef struct packed {
        logic              we;
        logic [2:0]        sel;
        logic [ROM_AW-1:0] addr;
        logic [ROM_DW-1:0] data;
    } rom_write_t;

    // Timing outputs toward the monitor
    typedef struct packed {
        logic xStep;        // Column X step pulse
        logic rampUp;       // Y ramp direction, high is upward
        logic colDelay;     // Adjustable column delay running
        logic charSpace;    // Move right to next character
    } monitor_timing_t;

endpackage

// >>> testbench/crt_monitor_model.sv
// Purpose: CRT monitor stand-in counting dots and X steps
// Assumes: Unblank active low, one X step pulse per column
// Notes:   Counters only; the monitor drives nothing back
`timescale 1ns/1ps
module crt_monitor_model (
    input wire logic                             sys_clk,
    input wire logic                             beam_unblank_out_n,
    input wire stroke_char_pkg::monitor_timing_t timing
);
    int   dotCount  = 0; // Unblanked dots
    int   stepCount = 0; // X steps taken
    logic lastBeam  = 1; // Unblank level one cycle back
    // Count each unblank start and each X step
    always @(posedge sys_clk) begin
        lastBeam <= beam_unblank_out_n;
        if (lastBeam && !beam_unblank_out_n) dotCount <= dotCount + 1;
        if (timing.xStep) stepCount <= stepCount + 1;
    end
endmodule

// >>> testbench/stroke_char_monitor.sv
// Purpose: Port assertions of the stroke character generator
// Assumes: Bench sets PULSE_LEN 3 and COL_DELAY 5
// Notes:   Bound to the generator from tb_top
`timescale 1ns/1ps
module stroke_char_monitor (
    input wire logic                             sys_clk,
    input wire logic                             rst_n,
    input wire logic                             end_of_char_n,
    input wire logic                             char_done,
    input wire logic                             dot_intensity,
    input wire logic                             beam_unblank_out_n,
    input wire logic                             shift_load_n,
    input wire logic                             column_msb_n,
    input wire logic                             last_column_n,
    input wire stroke_char_pkg::monitor_timing_t timing
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_unblank; beam_unblank_out_n == !dot_intensity; endproperty
    a_unblank: assert property (p_unblank) else $error("unblank not inverse of intensity");
    property p_pulse; $rose(dot_intensity) |-> dot_intensity [*3] ##1 !dot_intensity; endproperty
    a_pulse: assert property (p_pulse) else $error("intensity pulse length wrong");
    property p_delay; $rose(timing.colDelay) |-> timing.colDelay [*5] ##1 !timing.colDelay; endproperty
    a_delay: assert property (p_delay) else $error("column delay length wrong");
    property p_done; char_done |-> timing.charSpace && !last_column_n; endproperty
    a_done: assert property (p_done) else $error("done outside column six");
    property p_eoc; char_done |-> !end_of_char_n ##1 !char_done; endproperty
    a_eoc: assert property (p_eoc) else $error("no end of character after done");
    property p_preset; $fell(end_of_char_n) |-> ##[1:3] column_msb_n; endproperty
    a_preset: assert property (p_preset) else $error("column not preset");
    property p_step; timing.xStep |=> !column_msb_n; endproperty
    a_step: assert property (p_step) else $error("X step outside columns");
    property p_load; !shift_load_n |-> !column_msb_n; endproperty
    a_load: assert property (p_load) else $error("load outside columns");
    property p_idle; !end_of_char_n |-> !dot_intensity; endproperty
    a_idle: assert property (p_idle) else $error("dot while idle");
endmodule

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench of the stroke character generator
// Assumes: One step every 16 clocks, short delay and pulse counts
// Notes:   Dots are counted by the CRT model
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk = 0, rst_n = 0, power_init_pulse = 0, dot_step_clock = 0;
    logic        charValid = 0, stepEn = 0;
    logic [6:0]  charCode = 7'h00;
    logic [15:0] romWrite = '0;
    logic        charReady, end_of_char_n, char_done, dot_intensity, beam_unblank_out_n;
    logic        shift_load_n, column_msb_n, first_column_n, last_column_n;
    logic [3:0]  timing;
    int          miscompares = 0, check_count = 0, phase = 0, n, d0, x0;
    logic [6:0]  rows [3] = '{7'h01, 7'h3c, 7'h7f}; // Low half, low half below its edge, high half
    always #2 sys_clk = ~sys_clk;
    // Step clock 8 high, 8 low; frozen while stepEn is low
    always @(negedge sys_clk) if (stepEn) begin phase <= phase + 1; dot_step_clock <= phase[3]; end
    stroke_char_gen #(.COL_DELAY(5), .PULSE_LEN(3)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .power_init_pulse(power_init_pulse), .dot_step_clock(dot_step_clock), .charCode(charCode),
        .charValid(charValid), .charReady(charReady), .romWrite(romWrite), .end_of_char_n(end_of_char_n),
        .char_done(char_done), .dot_intensity(dot_intensity), .beam_unblank_out_n(beam_unblank_out_n),
        .shift_load_n(shift_load_n), .column_msb_n(column_msb_n), .first_column_n(first_column_n),
        .last_column_n(last_column_n), .timing(timing));
    crt_monitor_model u_crt (.sys_clk(sys_clk), .beam_unblank_out_n(beam_unblank_out_n), .timing(timing));
    function automatic logic [3:0] romVal(input int s, input logic [7:0] a);
        return a[3:0] ^ a[7:4] ^ 4'(s);
    endfunction
    // Expected dots: ROM pair by code half and column
    function automatic int dots(input logic [6:0] c);
        int t = 0;
        int s;
        logic [7:0] a;
        for (int k = 0; k < 6; k++) begin
            s = (k > 3) ? 4 : (c[6] ? 2 : 0);
            a = (k > 3) ? {c, k[0]} : {c[5:0], k[1:0]};
            t += $countones({romVal(s + 1, a), romVal(s, a)});
        end
        return t;
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task push(input logic [6:0] c);
        @(negedge sys_clk);
        charCode = c;
        charValid = 1;
        @(negedge sys_clk);
        charValid = 0;
    endtask
    task waitDone(input int k);
        n = 0;
        while (k > 0 && n < 20000) begin
            @(negedge sys_clk);
            n++;
            if (char_done === 1'b1) k--;
        end
        chk(n < 20000, 1);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1;
        chk(end_of_char_n, 1);
        power_init_pulse = 1;
        repeat (8) @(negedge sys_clk);
        chk(end_of_char_n, 0);
        chk(column_msb_n, 1);
        power_init_pulse = 0;
        for (int s = 0; s < 6; s++) for (int a = 0; a < 256; a++) begin
            romWrite = {1'b1, 3'(s), 8'(a), romVal(s, 8'(a))};
            @(negedge sys_clk);
        end
        romWrite = '0;
        stepEn = 1;
        foreach (rows[i]) begin
            d0 = u_crt.dotCount;
            x0 = u_crt.stepCount;
            push(rows[i]);
            waitDone(1);
            chk(u_crt.dotCount - d0, dots(rows[i]));
            chk(u_crt.stepCount - x0, 6);
            $display("row %0d done", i);
        end
        stepEn = 0;
        for (int i = 0; i < 6; i++) push(7'(i + 16));
        chk(charReady, 0);
        stepEn = 1;
        waitDone(5);
        chk(charReady, 1);
        $display("fifo test done");
        push(7'h41);
        repeat (300) @(negedge sys_clk);
        rst_n = 0;
        @(negedge sys_clk);
        chk({char_done, dot_intensity, end_of_char_n, beam_unblank_out_n}, 4'h3);
        rst_n = 1;
        $display("reset test done");
        test_done;
    end
    initial begin
        #200000;
        miscompares++;
        test_done;
    end
endmodule
bind stroke_char_gen stroke_char_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .end_of_char_n(end_of_char_n),
    .char_done(char_done), .dot_intensity(dot_intensity), .beam_unblank_out_n(beam_unblank_out_n),
    .shift_load_n(shift_load_n), .column_msb_n(column_msb_n), .last_column_n(last_column_n), .timing(timing));
